// file: rtl/motor_commutation_pkg.sv
// Constants for the brushless motor commutation and tachometer core.
// Assumes a single 20 MHz clock and synchronous inputs.
package motor_commutation_pkg;
    localparam int unsigned CLOCK_HZ          = 20_000_000;
    // Default tachometer on time in ns (programmable at the port)
    localparam int unsigned TACH_ON_NS        = 25_000;
    localparam int unsigned TACH_ON_CYCLES    =
        (TACH_ON_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned TACH_WIDTH        = 16;
    // Triangle counter limits stand in for the 2.5 V and 7.5 V levels
    localparam int unsigned RAMP_WIDTH        = 12;
    localparam logic [11:0] RAMP_LOW          = 12'h000;
    localparam logic [11:0] RAMP_HIGH_DEFAULT = 12'h3E7;
    // Reset values
    localparam logic [2:0]  SENSOR_RESET      = 3'h0;
    localparam logic        DIR_RESET         = 1'b0;

    typedef enum logic [1:0] {
        RAMP_RISE,
        RAMP_FALL
    } ramp_phase_t;
endpackage

// file: rtl/bldc_commutation_tach_logic.sv
// Commutation decoder, inhibits, PWM gating, direction, tachometer and
// triangle oscillator of a three-phase brushless motor controller.
// Assumes all inputs are already synchronous to I_CLOCK.
`timescale 1ns/1ns

// Summary of operation
// - Brake: high sides off, low sides on while PWM compare is on
// - Tachometer keeps running during brake
// - Brake low sides inhibited only by listed causes
// - Coast turns all six commands off
// - Direction input selects decode order
// - Classify next sensor state as cw/ccw
// - Motoring direction output equals direction input after a forward step, its inverse after a backward step
// - Quad low: PWM gates low side only
// - Quad high: PWM gates both sides
// - Supply lockout holds all commands off
// - Any sensor edge triggers tachometer pulse
// - Edge during pulse restarts its timing
// - Pulse width fixed and programmable
// - Triangle ramps between lower and upper limits
// - Sync rising edge forces falling phase
module bldc_commutation_tach_logic
    import motor_commutation_pkg::*;
#(
    parameter int unsigned TACH_CYCLES_DEFAULT = TACH_ON_CYCLES
) (
    input  wire logic                  I_CLOCK,
    input  wire logic                  I_SRST,
    input  wire logic                  I_ROTOR_SENSOR_A,
    input  wire logic                  I_ROTOR_SENSOR_B,
    input  wire logic                  I_ROTOR_SENSOR_C,
    input  wire logic                  I_DIRECTION_CMD,
    input  wire logic                  I_BRAKE,
    input  wire logic                  I_COAST,
    input  wire logic                  I_QUAD_SELECT,
    input  wire logic                  I_SUPPLY_LOW_LOCKOUT,
    input  wire logic                  I_OVERCURRENT_TRIP,
    input  wire logic                  I_PWM_COMPARE_ON,
    input  wire logic                  I_OSCILLATOR_ALIGN_PULSE,
    input  wire logic [TACH_WIDTH-1:0] I_TACH_ON_CYCLES,
    input  wire logic [RAMP_WIDTH-1:0] I_RAMP_HIGH,
    output logic                       O_HIGH_SIDE_DRIVE_A,
    output logic                       O_HIGH_SIDE_DRIVE_B,
    output logic                       O_HIGH_SIDE_DRIVE_C,
    output logic                       O_LOW_SIDE_DRIVE_A,
    output logic                       O_LOW_SIDE_DRIVE_B,
    output logic                       O_LOW_SIDE_DRIVE_C,
    output logic                       O_DIRECTION_ACTUAL,
    output logic                       O_SPEED_PULSE_OUT,
    output logic [RAMP_WIDTH-1:0]      O_RAMP_LEVEL,
    output logic                       O_RAMP_FALLING
);

    // Step index 0..5 of a sensor code in forward order, 7 if invalid
    function automatic logic [2:0] step_of(input logic [2:0] code);
        unique case (code)
            3'h5:    step_of = 3'h0;
            3'h4:    step_of = 3'h1;
            3'h6:    step_of = 3'h2;
            3'h2:    step_of = 3'h3;
            3'h3:    step_of = 3'h4;
            3'h1:    step_of = 3'h5;
            default: step_of = 3'h7;
        endcase
    endfunction

    function automatic logic [2:0] step_next(input logic [2:0] s);
        step_next = (s == 3'h5) ? 3'h0 : 3'(s + 3'h1);
    endfunction

    logic [2:0]            sensors;
    logic [2:0]            last_sensors;
    logic                  sensors_primed;
    logic [2:0]            step;
    logic [2:0]            last_step;
    logic                  valid;
    logic [2:0]            hi_sel;
    logic [2:0]            lo_sel;
    logic                  inhibit_all;
    logic                  hi_pwm_gate;
    logic [2:0]            hi_cmd;
    logic [2:0]            lo_cmd;
    logic                  sensor_edge;
    logic                  went_forward;
    logic                  went_back;
    logic [TACH_WIDTH-1:0] tach_count;
    logic                  sync_last;
    logic                  sync_rise;
    ramp_phase_t           phase;
    logic [RAMP_WIDTH-1:0] ramp;

    assign sensors = {I_ROTOR_SENSOR_A, I_ROTOR_SENSOR_B, I_ROTOR_SENSOR_C};
    assign step    = step_of(sensors);
    assign valid   = (step != 3'h7);

    // one high one low
    // Forward: high phase advances A,A,B,B,C,C; reverse swaps hi and lo
    logic [2:0] fwd_hi;
    logic [2:0] fwd_lo;
    assign fwd_hi = (step == 3'h0 || step == 3'h1) ? 3'h4 :
                    (step == 3'h2 || step == 3'h3) ? 3'h2 : 3'h1;
    assign fwd_lo = (step == 3'h0 || step == 3'h5) ? 3'h2 :
                    (step == 3'h1 || step == 3'h2) ? 3'h1 : 3'h4;
    assign hi_sel = I_DIRECTION_CMD ? fwd_hi : fwd_lo;
    assign lo_sel = I_DIRECTION_CMD ? fwd_lo : fwd_hi;

    assign inhibit_all = I_SUPPLY_LOW_LOCKOUT | I_COAST |
                         I_OVERCURRENT_TRIP;
    assign hi_pwm_gate = I_QUAD_SELECT ? I_PWM_COMPARE_ON : 1'b1;

    assign hi_cmd = (inhibit_all | I_BRAKE | !valid) ? 3'h0 :
                    (hi_pwm_gate ? hi_sel : 3'h0);
    assign lo_cmd = (inhibit_all | !I_PWM_COMPARE_ON) ? 3'h0 :
                    I_BRAKE ? 3'h7 :
                    (valid ? lo_sel : 3'h0);

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            {O_HIGH_SIDE_DRIVE_A, O_HIGH_SIDE_DRIVE_B,
             O_HIGH_SIDE_DRIVE_C} <= 3'h0;
            {O_LOW_SIDE_DRIVE_A, O_LOW_SIDE_DRIVE_B,
             O_LOW_SIDE_DRIVE_C} <= 3'h0;
        end else begin
            {O_HIGH_SIDE_DRIVE_A, O_HIGH_SIDE_DRIVE_B,
             O_HIGH_SIDE_DRIVE_C} <= hi_cmd;
            {O_LOW_SIDE_DRIVE_A, O_LOW_SIDE_DRIVE_B,
             O_LOW_SIDE_DRIVE_C} <= lo_cmd;
        end
    end

    assign sensor_edge  = sensors_primed && (sensors != last_sensors);
    assign last_step    = step_of(last_sensors);
    assign went_forward = sensor_edge && valid && last_step != 3'h7 &&
                          step == step_next(last_step);
    assign went_back    = sensor_edge && valid && last_step != 3'h7 &&
                          last_step == step_next(step);

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            last_sensors   <= SENSOR_RESET;
            sensors_primed <= 1'b0;
            O_DIRECTION_ACTUAL <= DIR_RESET;
        end else begin
            last_sensors   <= sensors;
            sensors_primed <= 1'b1;
            if (went_forward)
                O_DIRECTION_ACTUAL <= I_DIRECTION_CMD;
            else if (went_back)
                O_DIRECTION_ACTUAL <= !I_DIRECTION_CMD;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST)
            tach_count <= '0;
        else if (sensor_edge)
            tach_count <= (I_TACH_ON_CYCLES == '0) ? TACH_WIDTH'(1) :
                          I_TACH_ON_CYCLES;
        else if (tach_count != '0)
            tach_count <= tach_count - TACH_WIDTH'(1);
    end
    assign O_SPEED_PULSE_OUT = (tach_count != '0);

    assign sync_rise = I_OSCILLATOR_ALIGN_PULSE & ~sync_last;

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            sync_last <= 1'b0;
            phase     <= RAMP_RISE;
            ramp      <= RAMP_LOW;
        end else begin
            sync_last <= I_OSCILLATOR_ALIGN_PULSE;
            if (sync_rise) begin
                phase <= RAMP_FALL;
                if (ramp != RAMP_LOW)
                    ramp <= ramp - RAMP_WIDTH'(1);
            end else begin
                unique case (phase)
                    RAMP_RISE: begin
                        if (ramp >= I_RAMP_HIGH)
                            phase <= RAMP_FALL;
                        else
                            ramp <= ramp + RAMP_WIDTH'(1);
                    end
                    RAMP_FALL: begin
                        if (ramp == RAMP_LOW)
                            phase <= RAMP_RISE;
                        else
                            ramp <= ramp - RAMP_WIDTH'(1);
                    end
                endcase
            end
        end
    end
    assign O_RAMP_LEVEL   = ramp;
    assign O_RAMP_FALLING = (phase == RAMP_FALL);

    brake_drive_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        I_BRAKE && !inhibit_all && I_PWM_COMPARE_ON |=>
        {O_HIGH_SIDE_DRIVE_A, O_HIGH_SIDE_DRIVE_B, O_HIGH_SIDE_DRIVE_C,
         O_LOW_SIDE_DRIVE_A, O_LOW_SIDE_DRIVE_B, O_LOW_SIDE_DRIVE_C}
        == 6'h07)
        else $error("brake drive wrong");
    coast_off_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        I_COAST || I_SUPPLY_LOW_LOCKOUT |=>
        {O_HIGH_SIDE_DRIVE_A, O_HIGH_SIDE_DRIVE_B, O_HIGH_SIDE_DRIVE_C,
         O_LOW_SIDE_DRIVE_A, O_LOW_SIDE_DRIVE_B, O_LOW_SIDE_DRIVE_C}
        == 6'h00)
        else $error("coast or lockout not off");
    invalid_off_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        !valid && !I_BRAKE |=> {O_HIGH_SIDE_DRIVE_A, O_HIGH_SIDE_DRIVE_B,
        O_HIGH_SIDE_DRIVE_C, O_LOW_SIDE_DRIVE_A, O_LOW_SIDE_DRIVE_B,
        O_LOW_SIDE_DRIVE_C} == 6'h00)
        else $error("invalid code drives");
    one_pair_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        valid && !I_BRAKE && !inhibit_all && I_PWM_COMPARE_ON |->
        $onehot(hi_cmd) && $onehot(lo_cmd) && (hi_cmd & lo_cmd) == 3'h0)
        else $error("bad phase pair");
    quad_two_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        valid && !I_BRAKE && !inhibit_all && !I_QUAD_SELECT &&
        !I_PWM_COMPARE_ON |=>
        $onehot({O_HIGH_SIDE_DRIVE_A, O_HIGH_SIDE_DRIVE_B,
                 O_HIGH_SIDE_DRIVE_C}) &&
        {O_LOW_SIDE_DRIVE_A, O_LOW_SIDE_DRIVE_B, O_LOW_SIDE_DRIVE_C}
        == 3'h0)
        else $error("high side chopped in two-quadrant");
    quad_four_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        I_QUAD_SELECT && !I_PWM_COMPARE_ON |-> hi_cmd == 3'h0 &&
        lo_cmd == 3'h0)
        else $error("four-quadrant gating wrong");
    tach_start_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        sensor_edge && I_TACH_ON_CYCLES > 16'h0001 |=>
        O_SPEED_PULSE_OUT [*2])
        else $error("tach pulse missing");
    tach_width_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        sensor_edge |=> tach_count == (($past(I_TACH_ON_CYCLES) == '0) ?
        TACH_WIDTH'(1) : $past(I_TACH_ON_CYCLES)))
        else $error("tach width not reloaded");
    motor_dir_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        went_forward |=> O_DIRECTION_ACTUAL == $past(I_DIRECTION_CMD))
        else $error("direction output wrong");
    sync_fall_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        sync_rise |=> phase == RAMP_FALL)
        else $error("sync did not force fall");
    ramp_bound_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
        phase == RAMP_RISE && ramp < I_RAMP_HIGH && !sync_rise |=>
        ramp == $past(ramp) + RAMP_WIDTH'(1))
        else $error("ramp not rising");

endmodule

// file: tb/rotor_sensor_model.sv
// Rotor position sensor model: steps the six-state sensor sequence.
// Assumes step or back is pulsed for one clock at a time.
`timescale 1ns/1ns
module rotor_sensor_model (
    input  wire logic       i_clock,
    input  wire logic       i_step,
    input  wire logic       i_back,
    input  wire logic       i_bad,
    input  wire logic       i_bad_level,
    output logic      [2:0] o_code
);
    localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    logic [2:0] pos = 3'h0;
    always_ff @(posedge i_clock) begin
        if (i_step) begin
            pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
        end else if (i_back) begin
            pos <= (pos == 3'h0) ? 3'h5 : pos - 3'h1;
        end
    end
    assign o_code = i_bad ? {3{i_bad_level}} : SEQ[pos];
endmodule

// file: tb/bldc_commutation_tach_logic_bench.sv
// Self-checking bench for the commutation and tachometer core.
// Assumes the sensor model is compiled first.
`timescale 1ns/1ns
module bldc_commutation_tach_logic_bench;
    import motor_commutation_pkg::*;
    localparam int          N   = 8;
    localparam logic [11:0] TOP = 12'h00A;
    localparam logic [2:0]  FHI [6] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
    localparam logic [2:0]  FLO [6] = '{3'h2, 3'h1, 3'h1, 3'h4, 3'h4, 3'h2};
    logic        clk, srst, step, back, bad, bad_lvl, align, tach, fall;
    logic [6:0]  ctl;
    logic [11:0] lvl, prev, lo, hi;
    wire  [2:0]  code;
    wire  [5:0]  drv;
    logic        dir_out;
    int          fails, cmp_count, cycles, pos, hi_len, last_len, jumps;
    rotor_sensor_model i_rotor_sensor_model (.i_clock(clk), .i_step(step),
        .i_back(back), .i_bad(bad), .i_bad_level(bad_lvl), .o_code(code));
    bldc_commutation_tach_logic i_bldc_commutation_tach_logic (
        .I_CLOCK(clk), .I_SRST(srst), .I_ROTOR_SENSOR_A(code[2]),
        .I_ROTOR_SENSOR_B(code[1]), .I_ROTOR_SENSOR_C(code[0]),
        .I_DIRECTION_CMD(ctl[6]), .I_QUAD_SELECT(ctl[5]),
        .I_BRAKE(ctl[4]), .I_COAST(ctl[3]), .I_SUPPLY_LOW_LOCKOUT(ctl[2]),
        .I_OVERCURRENT_TRIP(ctl[1]), .I_PWM_COMPARE_ON(ctl[0]),
        .I_OSCILLATOR_ALIGN_PULSE(align), .I_TACH_ON_CYCLES(16'(N)),
        .I_RAMP_HIGH(TOP), .O_HIGH_SIDE_DRIVE_A(drv[5]),
        .O_HIGH_SIDE_DRIVE_B(drv[4]), .O_HIGH_SIDE_DRIVE_C(drv[3]),
        .O_LOW_SIDE_DRIVE_A(drv[2]), .O_LOW_SIDE_DRIVE_B(drv[1]),
        .O_LOW_SIDE_DRIVE_C(drv[0]), .O_DIRECTION_ACTUAL(dir_out),
        .O_SPEED_PULSE_OUT(tach), .O_RAMP_LEVEL(lvl), .O_RAMP_FALLING(fall));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            fails++;
            end_sim();
        end
    end
    always @(negedge clk) begin
        if (tach === 1'b1) begin
            hi_len++;
        end else if (hi_len != 0) begin
            last_len = hi_len;
            hi_len = 0;
        end
    end
    task automatic cmp_val(input string n, input logic [11:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_num(input string n, input int e, g);
        cmp_count++;
        if (g != e) begin
            fails++;
            $display("unexpected %s expected %0d seen %0d", n, e, g);
        end
    endtask
    function automatic logic [5:0] exp_drv(input int p, input logic [6:0] v,
                                           input logic inv);
        logic [2:0] h;
        logic [2:0] l;
        h = v[6] ? FHI[p] : FLO[p];
        l = v[6] ? FLO[p] : FHI[p];
        if (v[3] || v[2] || v[1]) return 6'h00;
        if (v[4]) return v[0] ? 6'h07 : 6'h00;
        if (inv) return 6'h00;
        if (!v[0]) l = 3'h0;
        if (!v[0] && v[5]) h = 3'h0;
        return {h, l};
    endfunction
    task automatic sweep(input logic inv);
        for (int v = 0; v < 128; v++) begin
            if (inv && v[4]) continue;
            @(posedge clk) ctl <= 7'(v);
            @(posedge clk);
            @(negedge clk);
            cmp_val("drives", 12'(exp_drv(pos, 7'(v), inv)), 12'(drv));
        end
    endtask
    task automatic move(input logic fwd);
        @(posedge clk) begin
            step <= fwd;
            back <= !fwd;
        end
        @(posedge clk) begin
            step <= 1'b0;
            back <= 1'b0;
        end
        pos = fwd ? (pos + 1) % 6 : (pos + 5) % 6;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic tach_len(input int e);
        for (int k = 0; k < 60 && last_len == 0; k++) @(negedge clk);
        cmp_num("pulse length", e, last_len);
    endtask
    initial begin
        srst = 1'b1;
        {step, back, bad, bad_lvl, align} = 5'h00;
        ctl = 7'h00;
        fails = 0;
        cmp_count = 0;
        cycles = 0;
        pos = 0;
        hi_len = 0;
        last_len = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int p = 0; p < 6; p++) begin
            sweep(1'b0);
            move(1'b1);
        end
        @(posedge clk) bad <= 1'b1;
        sweep(1'b1);
        @(posedge clk) bad_lvl <= 1'b1;
        sweep(1'b1);
        @(posedge clk) bad <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) ctl <= {k[0], 6'h01};
            move(k[1]);
            move(k[1]);
            cmp_val("direction", 12'(k[1] ? k[0] : !k[0]), 12'(dir_out));
        end
        @(posedge clk) ctl <= 7'h11;
        repeat (20) @(posedge clk);
        last_len = 0;
        move(1'b1);
        tach_len(N);
        last_len = 0;
        move(1'b0);
        move(1'b0);
        tach_len(N + 5);
        {lo, hi, jumps} = {12'hFFF, 12'h000, 32'h0};
        @(negedge clk) prev = lvl;
        repeat (60) @(negedge clk) begin
            lo = (lvl < lo) ? lvl : lo;
            hi = (lvl > hi) ? lvl : hi;
            // Turning points dwell one clock at either limit
            jumps += (lvl !== prev + 12'h1 && lvl !== prev - 12'h1 &&
                      !(lvl === prev && (lvl === TOP || lvl === 12'h000)));
            prev = lvl;
        end
        cmp_val("ramp top", TOP, hi);
        cmp_val("ramp bottom", 12'h000, lo);
        cmp_num("ramp jumps", 0, jumps);
        for (int k = 0; k < 40 && !(lvl === 12'h003 && fall === 1'b0); k++)
            @(negedge clk);
        @(posedge clk) align <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp_val("ramp falling", 12'h001, 12'(fall));
        cmp_val("ramp stopped", 12'h001, 12'(lvl <= 12'h005));
        @(posedge clk) align <= 1'b0;
        end_sim();
    end
endmodule
